// ==== design/async_receive_queue_formatter.v ====
// receive queue formatter: received packets, self-ID, PHY packets, confirmations
//
// Notes on behaviour
// R01: quadlet one holds destination and header; two and three source ID and offset/response code.
// R02: quadlet four holds quadlet data, or length plus reserved for block read requests.
// R03: every queued received packet ends with a reception status quadlet.
// R04: block quadlet four holds length and lock action; action zero unless lock.
// R05: block quadlets two/three source and offset or response code; payload follows four.
// R06: self-ID and PHY deliveries start with a made-up header of code 0xE.
// R07: all self-ID packets from reset end to subaction gap form one queued packet.
// R08: self-ID check quadlets are queued unchecked; the reader checks them.
// R09: self-ID status says data error on misalignment or overrun, else complete.
// R10: PHY packet queues only its first quadlet; check quadlet verified and dropped.
// R11: request confirmations go to request queue, response confirmations to response queue.
// R12: confirmation: destination 31..16, label 15..10, 00, code 1000, confirmation code.
// R13: confirmation 0 no ack, 1 broadcast or complete, 2 pending.
// R14: confirmation 4 when retries ran out without acceptance.
// R15: confirmation D on data error ack, E on type error ack.
// R16: only the defined confirmation codes are ever produced.
// R17: exactly one confirmation per transmitted queued packet.
// R18: status ack field holds the ack returned, or the one that would have been.
// R19: ack encodings complete 1, pending 2, busy 4/5/6, data error D, type error E.
// R20: transaction codes queued as received: 0,1,4,5,6,7,9,B,2.
// R21: status quadlet written only once the packet and its ack are complete.
`timescale 1ns/1ps
`include "async_receive_queue_formatter_regs.vh"
module async_receive_queue_formatter #(
  parameter CONF_ADDR_BITS = 2
) (
  // clock and reset
  input wire CLOCK,
  input wire RESET,
  // received quadlets from the link receiver
  input wire RX_VALID,
  input wire RX_FIRST,
  input wire [1:0] RX_KIND,
  input wire [31:0] RX_DATA,
  input wire RX_END,
  input wire [3:0] RX_ACK,
  input wire RX_ALIGN_ERROR,
  // bus phases
  input wire SELFID_ENABLE,
  input wire BUS_RESET_END,
  input wire SUBACTION_GAP,
  // transmission results
  input wire TX_DONE,
  input wire TX_IS_RESPONSE,
  input wire [15:0] TX_TARGET_NODE_ID,
  input wire [5:0] TX_LABEL,
  input wire TX_BROADCAST,
  input wire TX_ACK_SEEN,
  input wire [3:0] TX_ACK,
  input wire TX_RETRY_EXCEEDED,
  output wire TX_CONF_READY,
  // request receive queue write port
  input wire REQ_Q_READY,
  output reg REQ_Q_WRITE,
  output reg [31:0] REQ_Q_DATA,
  // response receive queue write port
  input wire RSP_Q_READY,
  output reg RSP_Q_WRITE,
  output reg [31:0] RSP_Q_DATA
);

  localparam S_IDLE = 2'd0;
  localparam S_ASYNC = 2'd1;
  localparam S_SELFID = 2'd2;
  localparam S_PHY = 2'd3;

  localparam [CONF_ADDR_BITS:0] CONF_FULL = {1'b1, {CONF_ADDR_BITS{1'b0}}};

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function is_response;
    input [3:0] tc;
    begin
      is_response = (tc == `TCODE_WRITE_RSP) || (tc == `TCODE_QUAD_READ_RSP) ||
        (tc == `TCODE_BLOCK_READ_RSP) || (tc == `TCODE_LOCK_RSP);
    end
  endfunction

  // block formats whose length quadlet carries no lock action
  function clears_low_half;
    input [3:0] tc;
    begin
      clears_low_half = (tc == `TCODE_BLOCK_WRITE_REQ) || (tc == `TCODE_BLOCK_READ_REQ) ||
        (tc == `TCODE_BLOCK_READ_RSP);
    end
  endfunction

  function [31:0] status_quadlet;
    input [3:0] ack_returned_field;
    begin
      status_quadlet = {28'h0000000, ack_returned_field};
    end
  endfunction

  function [3:0] conf_code;
    input bcast;
    input ack_seen;
    input [3:0] ack;
    input retry_exceeded;
    begin
      if (retry_exceeded && !bcast) begin
        conf_code = `CONF_RETRY_LIMIT; // [R14]
      end else if (bcast) begin
        conf_code = `CONF_COMPLETE; // [R13]
      end else if (!ack_seen) begin
        conf_code = `CONF_NO_ACK; // [R13]
      end else begin
        case (ack)
          `ACK_COMPLETE: conf_code = `CONF_COMPLETE; // [R13] [R19]
          `ACK_PENDING: conf_code = `CONF_PENDING; // [R13] [R19]
          `ACK_DATA_ERROR: conf_code = `CONF_DATA_ERROR; // [R15] [R19]
          `ACK_TYPE_ERROR: conf_code = `CONF_TYPE_ERROR; // [R15] [R19]
          default: conf_code = `CONF_NO_ACK; // [R16]
        endcase
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // receive state

  reg [1:0] state;
  reg in_resp;
  reg [3:0] tcode;
  reg [2:0] qindex;
  reg err;
  reg [31:0] phy_word;
  reg phy_ok;
  reg [1:0] phy_count;
  reg [1:0] phy_step;

  reg rx_wr;
  reg rx_resp;
  reg [31:0] rx_word;
  wire rx_target_ready;

  assign rx_target_ready = rx_resp ? RSP_Q_READY : REQ_Q_READY;

  // quadlet to be written by the receive side this cycle
  always @* begin
    rx_wr = 1'b0;
    rx_resp = 1'b0;
    rx_word = 32'h00000000;
    case (state)
      S_IDLE: begin
        if (BUS_RESET_END && SELFID_ENABLE) begin
          rx_wr = 1'b1;
          rx_word = {24'h000000, `TCODE_SELFID_PHY, 4'h0}; // [R06]
        end else if (RX_VALID && RX_FIRST && RX_KIND == `KIND_ASYNC) begin
          rx_wr = 1'b1;
          rx_resp = is_response(RX_DATA[`TCODE_MSB:`TCODE_LSB]); // [R20]
          rx_word = RX_DATA; // [R01]
        end
      end
      S_ASYNC: begin
        rx_resp = in_resp;
        if (RX_VALID) begin
          rx_wr = 1'b1;
          rx_word = RX_DATA; // [R01] [R05]
          if (qindex == `LENGTH_QUADLET && clears_low_half(tcode)) begin
            rx_word = {RX_DATA[31:16], 16'h0000}; // [R02] [R04]
          end
        end else if (RX_END) begin
          rx_wr = 1'b1;
          rx_word = status_quadlet(RX_ACK); // [R03] [R18] [R21]
        end
      end
      S_SELFID: begin
        if (RX_VALID) begin
          rx_wr = 1'b1;
          rx_word = RX_DATA; // [R07] [R08]
        end else if (SUBACTION_GAP) begin
          rx_wr = 1'b1;
          rx_word = status_quadlet((err || RX_ALIGN_ERROR) ? `ACK_DATA_ERROR :
            `ACK_COMPLETE); // [R09] [R03] [R19]
        end
      end
      S_PHY: begin
        case (phy_step)
          2'd1: begin
            rx_wr = 1'b1;
            rx_word = {24'h000000, `TCODE_SELFID_PHY, 4'h0}; // [R06]
          end
          2'd2: begin
            rx_wr = 1'b1;
            rx_word = phy_word; // [R10]
          end
          2'd3: begin
            rx_wr = 1'b1;
            rx_word = status_quadlet(`ACK_COMPLETE); // [R03]
          end
          default: rx_wr = 1'b0;
        endcase
      end
      default: rx_wr = 1'b0;
    endcase
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      state <= S_IDLE;
      in_resp <= 1'b0;
      tcode <= 4'h0;
      qindex <= 3'h0;
      err <= 1'b0;
      phy_word <= 32'h00000000;
      phy_ok <= 1'b0;
      phy_count <= 2'h0;
      phy_step <= 2'h0;
    end else begin
      case (state)
        S_IDLE: begin
          err <= 1'b0;
          if (BUS_RESET_END && SELFID_ENABLE) begin
            state <= S_SELFID; // [R07]
          end else if (RX_VALID && RX_FIRST && RX_KIND == `KIND_ASYNC) begin
            state <= S_ASYNC;
            tcode <= RX_DATA[`TCODE_MSB:`TCODE_LSB];
            in_resp <= is_response(RX_DATA[`TCODE_MSB:`TCODE_LSB]);
            qindex <= 3'h1;
          end else if (RX_VALID && RX_FIRST && RX_KIND == `KIND_PHY) begin
            state <= S_PHY;
            phy_word <= RX_DATA;
            phy_count <= 2'h1;
            phy_ok <= 1'b0;
            phy_step <= 2'h0;
          end
        end
        S_ASYNC: begin
          if (RX_VALID && qindex != 3'h7) begin
            qindex <= qindex + 3'h1;
          end else if (!RX_VALID && RX_END) begin
            state <= S_IDLE;
          end
        end
        S_SELFID: begin
          if (RX_ALIGN_ERROR || (rx_wr && !rx_target_ready)) begin
            err <= 1'b1; // [R09]
          end
          if (!RX_VALID && SUBACTION_GAP) begin
            state <= S_IDLE;
          end
        end
        S_PHY: begin
          if (phy_step == 2'd0) begin
            if (RX_VALID && phy_count != 2'h3) begin
              phy_count <= phy_count + 2'h1;
              if (phy_count == 2'h1) begin
                phy_ok <= (RX_DATA == ~phy_word); // [R10]
              end
            end else if (RX_END) begin
              if (phy_count == 2'h2 && phy_ok) begin
                phy_step <= 2'd1;
              end else begin
                state <= S_IDLE;
              end
            end
          end else if (phy_step == 2'd3) begin
            phy_step <= 2'd0;
            state <= S_IDLE;
          end else begin
            phy_step <= phy_step + 2'd1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending confirmations

  reg [CONF_ADDR_BITS-1:0] conf_wr_ptr;
  reg [CONF_ADDR_BITS-1:0] conf_rd_ptr;
  reg [CONF_ADDR_BITS:0] conf_count;
  reg conf_fresh;
  wire [32:0] conf_head;
  wire [32:0] conf_new;
  wire conf_push;
  wire conf_resp;
  wire req_busy;
  wire rsp_busy;
  wire conf_pop;

  assign TX_CONF_READY = (conf_count != CONF_FULL);
  assign conf_push = TX_DONE && TX_CONF_READY; // [R17]
  assign conf_new = {TX_IS_RESPONSE, TX_TARGET_NODE_ID, TX_LABEL, `CONF_RESERVED,
    `TCODE_CONFIRM, conf_code(TX_BROADCAST, TX_ACK_SEEN, TX_ACK,
    TX_RETRY_EXCEEDED)}; // [R12]
  assign conf_resp = conf_head[32];

  // a queue holding a packet in progress takes no confirmation until it ends
  assign req_busy = (state == S_SELFID) || (state == S_PHY) ||
    (state == S_ASYNC && !in_resp) || (rx_wr && !rx_resp);
  assign rsp_busy = (state == S_ASYNC && in_resp) || (rx_wr && rx_resp);
  assign conf_pop = conf_fresh && (conf_count != 0) &&
    (conf_resp ? (!rsp_busy && RSP_Q_READY) : (!req_busy && REQ_Q_READY)); // [R11]

  confirm_store #(
    .WIDTH(33),
    .ADDR_BITS(CONF_ADDR_BITS)
  ) u_store (
    .clk(CLOCK),
    .wr_en(conf_push),
    .wr_addr(conf_wr_ptr),
    .wr_data(conf_new),
    .rd_addr(conf_rd_ptr),
    .rd_data(conf_head)
  );

  always @(posedge CLOCK) begin
    if (RESET) begin
      conf_wr_ptr <= {CONF_ADDR_BITS{1'b0}};
      conf_rd_ptr <= {CONF_ADDR_BITS{1'b0}};
      conf_count <= {(CONF_ADDR_BITS+1){1'b0}};
      conf_fresh <= 1'b0;
    end else begin
      if (conf_push) begin
        conf_wr_ptr <= conf_wr_ptr + 1'b1;
      end
      if (conf_pop) begin
        conf_rd_ptr <= conf_rd_ptr + 1'b1;
      end
      if (conf_push && !conf_pop) begin
        conf_count <= conf_count + 1'b1;
      end else if (conf_pop && !conf_push) begin
        conf_count <= conf_count - 1'b1;
      end
      // head register needs one cycle after a pointer move or a first push
      conf_fresh <= (conf_count != 0) && !conf_pop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // queue write ports

  always @(posedge CLOCK) begin
    if (RESET) begin
      REQ_Q_WRITE <= 1'b0;
      REQ_Q_DATA <= 32'h00000000;
      RSP_Q_WRITE <= 1'b0;
      RSP_Q_DATA <= 32'h00000000;
    end else begin
      REQ_Q_WRITE <= 1'b0;
      RSP_Q_WRITE <= 1'b0;
      if (rx_wr && !rx_resp && REQ_Q_READY) begin
        REQ_Q_WRITE <= 1'b1;
        REQ_Q_DATA <= rx_word;
      end else if (conf_pop && !conf_resp) begin
        REQ_Q_WRITE <= 1'b1;
        REQ_Q_DATA <= conf_head[31:0]; // [R11]
      end
      if (rx_wr && rx_resp && RSP_Q_READY) begin
        RSP_Q_WRITE <= 1'b1;
        RSP_Q_DATA <= rx_word;
      end else if (conf_pop && conf_resp) begin
        RSP_Q_WRITE <= 1'b1;
        RSP_Q_DATA <= conf_head[31:0]; // [R11]
      end
    end
  end

endmodule // async_receive_queue_formatter

// ==== design/async_receive_queue_formatter_regs.vh ====
// constants of the asynchronous receive queue formatter
`ifndef ASYNC_RECEIVE_QUEUE_FORMATTER_REGS_VH
`define ASYNC_RECEIVE_QUEUE_FORMATTER_REGS_VH

// transaction codes as queued
`define TCODE_QUAD_WRITE_REQ 4'h0
`define TCODE_BLOCK_WRITE_REQ 4'h1
`define TCODE_WRITE_RSP 4'h2
`define TCODE_QUAD_READ_REQ 4'h4
`define TCODE_BLOCK_READ_REQ 4'h5
`define TCODE_QUAD_READ_RSP 4'h6
`define TCODE_BLOCK_READ_RSP 4'h7
`define TCODE_CONFIRM 4'h8
`define TCODE_LOCK_REQ 4'h9
`define TCODE_LOCK_RSP 4'hB
`define TCODE_SELFID_PHY 4'hE

// acknowledge codes
`define ACK_COMPLETE 4'h1
`define ACK_PENDING 4'h2
`define ACK_BUSY_X 4'h4
`define ACK_BUSY_A 4'h5
`define ACK_BUSY_B 4'h6
`define ACK_DATA_ERROR 4'hD
`define ACK_TYPE_ERROR 4'hE

// confirmation codes
`define CONF_NO_ACK 4'h0
`define CONF_COMPLETE 4'h1
`define CONF_PENDING 4'h2
`define CONF_RETRY_LIMIT 4'h4
`define CONF_DATA_ERROR 4'hD
`define CONF_TYPE_ERROR 4'hE

// field positions
`define TCODE_MSB 7
`define TCODE_LSB 4
`define LOCK_CODE_MSB 15
`define CONF_RESERVED 2'h0

// receive kinds given with the first quadlet
`define KIND_ASYNC 2'h0
`define KIND_PHY 2'h2

// quadlet index of the length / lock action quadlet
`define LENGTH_QUADLET 3'h3

`endif

// ==== design/confirm_store.v ====
// small memory holding pending confirmation quadlets
`timescale 1ns/1ps
module confirm_store #(
  parameter WIDTH = 33,
  parameter ADDR_BITS = 2
) (
  // clock
  input wire clk,
  // write side
  input wire wr_en,
  input wire [ADDR_BITS-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // read side
  input wire [ADDR_BITS-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:(1<<ADDR_BITS)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // confirm_store

// ==== verification/formatter_checker_assertions.sv ====
// port assertions of the asynchronous receive queue formatter
`timescale 1ns/1ps
module formatter_checker (
  // clock and reset
  input wire CLOCK,
  input wire RESET,
  // receiver side
  input wire RX_VALID,
  input wire RX_FIRST,
  input wire [1:0] RX_KIND,
  input wire [31:0] RX_DATA,
  input wire SELFID_ENABLE,
  input wire BUS_RESET_END,
  // queue side
  input wire TX_CONF_READY,
  input wire REQ_Q_READY,
  input wire REQ_Q_WRITE,
  input wire [31:0] REQ_Q_DATA,
  input wire RSP_Q_READY,
  input wire RSP_Q_WRITE,
  input wire [31:0] RSP_Q_DATA
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////////////////////////////////////////////
  a_conf_fixed_bits: assert property (REQ_Q_WRITE && REQ_Q_DATA[7:4] == 4'h8
    |-> REQ_Q_DATA[9:8] == 2'h0) else $error("confirmation bits 9..8 not zero");
  a_conf_code_legal: assert property (RSP_Q_WRITE && RSP_Q_DATA[7:4] == 4'h8
    |-> RSP_Q_DATA[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'hD, 4'hE})
    else $error("reserved confirmation code");
  a_selfid_header: assert property (BUS_RESET_END && SELFID_ENABLE && REQ_Q_READY
    && !RX_VALID |=> REQ_Q_WRITE && REQ_Q_DATA == 32'h000000E0)
    else $error("no self-ID header after bus reset");
  a_req_first_copy: assert property (RX_VALID && RX_FIRST && RX_KIND == 2'h0
    && RX_DATA[7:4] == 4'h0 && REQ_Q_READY |=> REQ_Q_WRITE && REQ_Q_DATA == $past(RX_DATA))
    else $error("request header not queued");
  a_rsp_routing: assert property (RX_VALID && RX_FIRST && RX_KIND == 2'h0
    && RX_DATA[7:4] == 4'h6 && RSP_Q_READY |=> RSP_Q_WRITE && RSP_Q_DATA == $past(RX_DATA))
    else $error("response header not in response queue");
  a_req_write_ready: assert property (REQ_Q_WRITE |-> $past(REQ_Q_READY))
    else $error("request queue written while not ready");
  a_rsp_write_ready: assert property (!$past(RSP_Q_READY) |-> !RSP_Q_WRITE)
    else $error("response queue written while not ready");
  a_req_data_holds: assert property (!REQ_Q_WRITE |-> $stable(REQ_Q_DATA))
    else $error("request queue data changed without write");
  a_store_free_reset: assert property ($fell(RESET) |-> TX_CONF_READY [*2])
    else $error("confirmation store not free after reset");
  c_req_conf: cover property (REQ_Q_WRITE && REQ_Q_DATA[7:4] == 4'h8);
  c_rsp_conf: cover property (RSP_Q_WRITE && RSP_Q_DATA[7:4] == 4'h8);
  c_selfid: cover property (BUS_RESET_END && SELFID_ENABLE);
  c_stall_end: cover property (!REQ_Q_READY ##1 REQ_Q_READY);
endmodule // formatter_checker

// ==== verification/queue_reader.sv ====
// model of the host reading one receive queue, able to stall
`timescale 1ns/1ps
module queue_reader (
  // clock
  input wire clock,
  // control from the bench
  input wire stall,
  // queue write port
  output wire ready,
  input wire write,
  input wire [31:0] data
);
  logic [31:0] got[$];
  assign ready = !stall;
  // every write is kept, check quadlets are verified by the bench
  always @(posedge clock) begin
    if (write) begin
      got.push_back(data);
    end
  end
endmodule // queue_reader

// ==== verification/tb.sv ====
// testbench of the asynchronous receive queue formatter
`timescale 1ns/1ps
module tb;
  logic CLOCK = 0, RESET = 1, RX_VALID = 0, RX_FIRST = 0, RX_END = 0, RX_ALIGN_ERROR = 0;
  logic SELFID_ENABLE = 1, BUS_RESET_END = 0, SUBACTION_GAP = 0, TX_DONE = 0;
  logic TX_IS_RESPONSE = 0, TX_BROADCAST = 0, TX_ACK_SEEN = 0, TX_RETRY_EXCEEDED = 0, STALL = 0;
  logic [1:0] RX_KIND = 2'h0;
  logic [3:0] RX_ACK = 4'h0, TX_ACK = 4'h0;
  logic [5:0] TX_LABEL = 6'h00;
  logic [15:0] TX_TARGET_NODE_ID = 16'h0000;
  logic [31:0] RX_DATA = 32'h00000000;
  wire TX_CONF_READY, REQ_Q_READY, REQ_Q_WRITE, RSP_Q_READY, RSP_Q_WRITE;
  wire [31:0] REQ_Q_DATA, RSP_Q_DATA;
  int miscompares = 0, tests_run = 0;
  always #20 CLOCK = ~CLOCK;
  async_receive_queue_formatter #(.CONF_ADDR_BITS(2)) dut (.CLOCK(CLOCK), .RESET(RESET),
    .RX_VALID(RX_VALID), .RX_FIRST(RX_FIRST), .RX_KIND(RX_KIND), .RX_DATA(RX_DATA),
    .RX_END(RX_END), .RX_ACK(RX_ACK), .RX_ALIGN_ERROR(RX_ALIGN_ERROR),
    .SELFID_ENABLE(SELFID_ENABLE), .BUS_RESET_END(BUS_RESET_END), .SUBACTION_GAP(SUBACTION_GAP),
    .TX_DONE(TX_DONE), .TX_IS_RESPONSE(TX_IS_RESPONSE), .TX_TARGET_NODE_ID(TX_TARGET_NODE_ID),
    .TX_LABEL(TX_LABEL), .TX_BROADCAST(TX_BROADCAST), .TX_ACK_SEEN(TX_ACK_SEEN),
    .TX_ACK(TX_ACK), .TX_RETRY_EXCEEDED(TX_RETRY_EXCEEDED), .TX_CONF_READY(TX_CONF_READY),
    .REQ_Q_READY(REQ_Q_READY), .REQ_Q_WRITE(REQ_Q_WRITE), .REQ_Q_DATA(REQ_Q_DATA),
    .RSP_Q_READY(RSP_Q_READY), .RSP_Q_WRITE(RSP_Q_WRITE), .RSP_Q_DATA(RSP_Q_DATA));
  queue_reader req_reader (.clock(CLOCK), .stall(STALL), .ready(REQ_Q_READY),
    .write(REQ_Q_WRITE), .data(REQ_Q_DATA));
  queue_reader rsp_reader (.clock(CLOCK), .stall(STALL), .ready(RSP_Q_READY),
    .write(RSP_Q_WRITE), .data(RSP_Q_DATA));
  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task check32(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task expect_q(input bit rsp, input logic [31:0] exp, input string what);
    int n;
    for (n = 0; n < 30 && (rsp ? rsp_reader.got.size() : req_reader.got.size()) == 0; n++) begin
      @(posedge CLOCK);
    end
    if (n == 30) begin
      miscompares++;
      $display("mismatch %s expected %h seen nothing", what, exp);
      stop_test();
    end else if (rsp) begin
      check32(what, exp, rsp_reader.got.pop_front());
    end else begin
      check32(what, exp, req_reader.got.pop_front());
    end
  endtask
  task check_empty(input string what);
    repeat (6) @(posedge CLOCK);
    check32(what, 32'h0, 32'(req_reader.got.size() + rsp_reader.got.size()));
  endtask
  task rxq(input logic first, input logic [1:0] kind, input logic [31:0] d);
    @(posedge CLOCK);
    RX_VALID <= 1'h1;
    RX_FIRST <= first;
    RX_KIND <= kind;
    RX_DATA <= d;
    @(posedge CLOCK);
    RX_VALID <= 1'h0;
    RX_FIRST <= 1'h0;
  endtask
  task rx_end(input logic [3:0] ack);
    @(posedge CLOCK);
    RX_END <= 1'h1;
    RX_ACK <= ack;
    @(posedge CLOCK);
    RX_END <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task async_packets;
    logic [3:0] tcs [9];
    logic [3:0] acks [7];
    logic [31:0] q [5];
    bit rsp;
    bit blk;
    int i;
    int k;
    tcs = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hB, 4'h2};
    acks = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'hD, 4'hE};
    for (i = 0; i < 9; i++) begin
      rsp = tcs[i] inside {4'h2, 4'h6, 4'h7, 4'hB};
      blk = tcs[i] inside {4'h1, 4'h5, 4'h7};
      q = '{{16'hFFC1, 8'h04, tcs[i], 4'h0}, 32'hFFC20000 + i, 32'h1000 + i, 32'h0010ABCD,
        32'hCAFE0000 + i};
      for (k = 0; k < 5; k++) rxq(k == 0, 2'h0, q[k]);
      rx_end(acks[i % 7]);
      for (k = 0; k < 5; k++) expect_q(rsp, (k == 3 && blk) ? 32'h00100000 : q[k], "quadlet");
      expect_q(rsp, {28'h0000000, acks[i % 7]}, "status");
    end
  endtask
  task self_id(input logic bad);
    logic [31:0] p;
    p = 32'h807F1234;
    @(posedge CLOCK);
    BUS_RESET_END <= 1'h1;
    @(posedge CLOCK);
    BUS_RESET_END <= 1'h0;
    rxq(1'h0, 2'h0, p);
    rxq(1'h0, 2'h0, ~p);
    rxq(1'h0, 2'h0, p + 32'h01000000);
    RX_ALIGN_ERROR <= bad;
    @(posedge CLOCK);
    RX_ALIGN_ERROR <= 1'h0;
    SUBACTION_GAP <= 1'h1;
    @(posedge CLOCK);
    SUBACTION_GAP <= 1'h0;
    expect_q(0, 32'h000000E0, "self-ID header");
    expect_q(0, p, "self-ID quadlet");
    expect_q(0, ~p, "check quadlet");
    expect_q(0, p + 32'h01000000, "second self-ID");
    expect_q(0, bad ? 32'h0000000D : 32'h00000001, "self-ID status");
  endtask
  task phy_packet(input logic [31:0] chk, input logic good);
    rxq(1'h1, 2'h2, 32'h00ABCDEF);
    rxq(1'h0, 2'h2, chk);
    rx_end(4'h1);
    repeat (4) @(posedge CLOCK);
    if (good) begin
      expect_q(0, 32'h000000E0, "PHY header");
      expect_q(0, 32'h00ABCDEF, "PHY quadlet");
      expect_q(0, 32'h00000001, "PHY status");
    end
  endtask
  task confirmations;
    logic [11:0] c [7];
    int i;
    c = '{12'h000, 12'h801, 12'h411, 12'h422, 12'h644, 12'h4DD, 12'h4EE};
    for (i = 0; i < 7; i++) begin
      @(posedge CLOCK);
      TX_DONE <= 1'h1;
      TX_IS_RESPONSE <= i[0];
      TX_TARGET_NODE_ID <= 16'hFFC0 + i[15:0];
      TX_LABEL <= 6'h20 + i[5:0];
      {TX_BROADCAST, TX_ACK_SEEN, TX_RETRY_EXCEEDED} <= c[i][11:9];
      TX_ACK <= c[i][7:4];
      @(posedge CLOCK);
      TX_DONE <= 1'h0;
      expect_q(i[0], {16'hFFC0 + i[15:0], 6'h20 + i[5:0], 2'h0, 4'h8, c[i][3:0]}, "conf");
    end
  endtask
  task conf_stall;
    @(posedge CLOCK);
    STALL <= 1'h1;
    TX_DONE <= 1'h1;
    TX_IS_RESPONSE <= 1'h0;
    TX_TARGET_NODE_ID <= 16'hFFFF;
    TX_LABEL <= 6'h3F;
    TX_BROADCAST <= 1'h1;
    repeat (4) @(posedge CLOCK);
    TX_DONE <= 1'h0;
    check_empty("stalled writes");
    check32("store full ready", 32'h0, {31'h0, TX_CONF_READY});
    STALL <= 1'h0;
    repeat (4) expect_q(0, 32'hFFFFFC81, "stored conf");
    check_empty("extra conf");
    check32("store drained ready", 32'h1, {31'h0, TX_CONF_READY});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge CLOCK);
    RESET <= 1'h0;
    async_packets();
    self_id(1'h0);
    self_id(1'h1);
    phy_packet(32'hFF543210, 1'h1);
    phy_packet(32'h00ABCDEF, 1'h0);
    check_empty("dropped PHY");
    confirmations();
    conf_stall();
    stop_test();
  end
endmodule // tb
bind async_receive_queue_formatter formatter_checker chk (.CLOCK(CLOCK), .RESET(RESET),
  .RX_VALID(RX_VALID), .RX_FIRST(RX_FIRST), .RX_KIND(RX_KIND), .RX_DATA(RX_DATA),
  .SELFID_ENABLE(SELFID_ENABLE), .BUS_RESET_END(BUS_RESET_END), .TX_CONF_READY(TX_CONF_READY),
  .REQ_Q_READY(REQ_Q_READY), .REQ_Q_WRITE(REQ_Q_WRITE), .REQ_Q_DATA(REQ_Q_DATA),
  .RSP_Q_READY(RSP_Q_READY), .RSP_Q_WRITE(RSP_Q_WRITE), .RSP_Q_DATA(RSP_Q_DATA));
